/* File: hdl/dssp_pkg.sv */
`default_nettype none
package dssp_pkg;
   // ------------------------------------------------------------
   // Serial frame layout
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int FRAME_BITS = 24;
   localparam int CNT_W = 5;
   localparam logic [4:0] CNT_LAST = 5'h17;
   localparam logic [4:0] CNT_OVER = 5'h18;
   // ------------------------------------------------------------
   // Target addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_UHF = 8'h01;
   localparam logic [7:0] ADDR_SBAND = 8'h02;
   localparam logic [7:0] ADDR_EDGE = 8'h03;
   // ------------------------------------------------------------
   // Divide word fields
   // ------------------------------------------------------------
   localparam int N_LSB = 8;
   localparam int N_W = 8;
   localparam int S_LSB = 5;
   localparam int S_W = 3;
   localparam int F_LSB = 0;
   localparam int F_W = 5;
   localparam int PS_BIT = 8;
   localparam logic [4:0] F_MAX = 5'h11;
   localparam int RATIO_W = 17;
   localparam logic [16:0] F_STEPS = 17'h00012;
   localparam logic [16:0] N_OFFSET = 17'h00003;
   localparam logic [16:0] N_SCALE = 17'h00008;
   // ------------------------------------------------------------
   // Reset values and pin idle levels
   // ------------------------------------------------------------
   localparam logic [15:0] UHF_RST = 16'h0000;
   localparam logic [15:0] SBAND_RST = 16'h0000;
   localparam logic [15:0] EDGE_RST = 16'h0000;
   localparam int GAIN_W = 5;
   localparam logic [2:0] LINK_SYNC_RST = 3'h4;
   localparam logic [6:0] PIN_SYNC_RST = 7'h00;
   localparam int UHF_M_DEF = 10;

   // Loop ratio in eighteenths of the reference
   function automatic logic [16:0] dssp_ratio(input logic [7:0] n,
                                              input logic [2:0] s,
                                              input logic [4:0] f);
      logic [16:0] whole;
      whole = N_SCALE * ({9'h000, n} + N_OFFSET) - {14'h0000, s};
      return F_STEPS * whole - {12'h000, f};
   endfunction : dssp_ratio
endpackage : dssp_pkg
`default_nettype wire

/* File: hdl/dssp_sync.sv */
`default_nettype none
module dssp_sync
   import dssp_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   // ------------------------------------------------------------
   // Two stage synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_r <= RST_VAL;
         hold_r <= RST_VAL;
      end else if (ce_in) begin
         meta_r <= d_in;
         hold_r <= meta_r;
      end
   end

   assign q_out = hold_r;
endmodule : dssp_sync
`default_nettype wire

/* File: hdl/dssp_word.sv */
`default_nettype none
module dssp_word
   import dssp_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [15:0] word_in,
   output logic [N_W-1:0] n_out,
   output logic [S_W-1:0] s_out,
   output logic [F_W-1:0] f_out,
   output logic [RATIO_W-1:0] ratio_out
);
   logic [N_W-1:0] n_r;
   logic [S_W-1:0] s_r;
   logic [F_W-1:0] f_r;
   logic [RATIO_W-1:0] ratio_r;

   // ------------------------------------------------------------
   // Field split and loop ratio
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         n_r <= '0;
         s_r <= '0;
         f_r <= '0;
         ratio_r <= '0;
      end else if (ce_in) begin
         n_r <= word_in[N_LSB +: N_W];
         s_r <= word_in[S_LSB +: S_W];
         f_r <= word_in[F_LSB +: F_W];
         ratio_r <= dssp_ratio(word_in[N_LSB +: N_W], word_in[S_LSB +: S_W],
                               word_in[F_LSB +: F_W]);
      end
   end

   assign n_out = n_r;
   assign s_out = s_r;
   assign f_out = f_r;
   assign ratio_out = ratio_r;
endmodule : dssp_word
`default_nettype wire

/* File: hdl/dssp_top.sv */
// Contract
// - Undriven serial data, clock and enable read as high.
// - Serial enable is a level, not an edge.
// - Each transfer is exactly twenty-four bits, three bytes.
// - First eight bits address, remaining sixteen bits payload.
// - First byte is address, bit 7 first.
// - Second byte holds payload bits 15 down to 8.
// - Payload loads divider, tap-drop, partial-step counts and edge choice.
// - Edge choice 1 selects rising reference edge, 0 falling.
// - Partial-step count only zero through seventeen.
// - UHF frequency uses loop ratio divided by twice output ratio.
// - S-band frequency uses loop ratio with no further division.
// - At most one S-band oscillator enabled at once.
// - One count step scales with reference frequency.
// - Five-bit parallel gain word sets transmit level in 1 dB steps.
// - Undriven gain and transmit-enable inputs read as low.
// - Writes to other addresses have no effect.
`default_nettype none
module dssp_top
   import dssp_pkg::*;
#(
   parameter int UHF_M = UHF_M_DEF
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic core_ce_in,
   input wire logic ser_clk_in,
   input wire logic ser_data_in,
   input wire logic ser_enable_in,
   input wire logic [GAIN_W-1:0] gain_in,
   input wire logic transmit_on_in,
   input wire logic sband_osc_pick_in,
   output logic [N_W-1:0] uhf_n_out,
   output logic [S_W-1:0] uhf_s_out,
   output logic [F_W-1:0] uhf_f_out,
   output logic [RATIO_W-1:0] uhf_ratio_out,
   output logic [7:0] uhf_post_div_out,
   output logic [N_W-1:0] sband_n_out,
   output logic [S_W-1:0] sband_s_out,
   output logic [F_W-1:0] sband_f_out,
   output logic [RATIO_W-1:0] sband_ratio_out,
   output logic edge_polarity_choice_out,
   output logic ref_rising_edge_out,
   output logic sband_osc_first_out,
   output logic sband_osc_second_out,
   output logic [GAIN_W-1:0] tx_gain_out,
   output logic transmit_on_out,
   output logic fully_programmed_out,
   output logic word_loaded_out,
   output logic word_rejected_out
);
   // ------------------------------------------------------------
   // Link domain signals
   // ------------------------------------------------------------
   logic link_clr;
   logic [FRAME_BITS-1:0] shift_r;
   logic [FRAME_BITS-1:0] shift_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [FRAME_BITS-1:0] frame_r;
   logic frame_tog_r;
   logic over_r;

   // ------------------------------------------------------------
   // Core domain signals
   // ------------------------------------------------------------
   logic [2:0] link_s;
   logic en_s;
   logic tog_s;
   logic over_s;
   logic [6:0] pin_s;
   logic en_d_r;
   logic tog_d_r;
   logic en_rise;
   logic en_fall;
   logic tog_evt;
   logic pend_r;
   logic bad_r;
   logic [FRAME_BITS-1:0] pend_word_r;
   logic [ADDR_W-1:0] pend_addr;
   logic [DATA_W-1:0] pend_data;
   logic commit;
   logic f_ok;
   logic hit_uhf;
   logic hit_sband;
   logic hit_edge;
   logic [DATA_W-1:0] uhf_word_r;
   logic [DATA_W-1:0] sband_word_r;
   logic [DATA_W-1:0] edge_word_r;
   logic uhf_done_r;
   logic sband_done_r;
   logic edge_done_r;
   logic loaded_r;
   logic rejected_r;
   logic first_r;
   logic second_r;
   logic [GAIN_W-1:0] gain_r;
   logic tx_on_r;

   // ------------------------------------------------------------
   // Link clock: shift register and bit count
   // ------------------------------------------------------------
   // level enable clear
   assign link_clr = sys_rst_in | ~ser_enable_in;
   assign shift_nxt = {shift_r[FRAME_BITS-2:0], ser_data_in};

   always_ff @(posedge ser_clk_in or posedge link_clr) begin
      if (link_clr) begin
         shift_r <= '0;
      end else begin
         shift_r <= shift_nxt;
      end
   end

   always_ff @(posedge ser_clk_in or posedge link_clr) begin
      if (link_clr) begin
         cnt_r <= '0;
      end else if (cnt_r != CNT_OVER) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

   always_ff @(posedge ser_clk_in or posedge link_clr) begin
      if (link_clr) begin
         over_r <= 1'b0;
      end else if (cnt_r >= CNT_LAST + 5'h01) begin
         over_r <= 1'b1;
      end
   end

   // Frame hold survives enable drop
   always_ff @(posedge ser_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         frame_r <= '0;
         frame_tog_r <= 1'b0;
      end else if (ser_enable_in && cnt_r == CNT_LAST) begin
         frame_r <= shift_nxt;
         frame_tog_r <= ~frame_tog_r;
      end
   end

   // ------------------------------------------------------------
   // Crossings into the core clock
   // ------------------------------------------------------------
   // idle levels: enable high, toggle and overrun low
   dssp_sync #(
      .W(3),
      .RST_VAL(LINK_SYNC_RST)
   ) u_link_sync (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .ce_in(core_ce_in),
      .d_in({ser_enable_in, frame_tog_r, over_r}),
      .q_out(link_s)
   );

   assign en_s = link_s[2];
   assign tog_s = link_s[1];
   assign over_s = link_s[0];

   dssp_sync #(
      .W(7),
      .RST_VAL(PIN_SYNC_RST)
   ) u_pin_sync (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .ce_in(core_ce_in),
      .d_in({gain_in, transmit_on_in, sband_osc_pick_in}),
      .q_out(pin_s)
   );

   // ------------------------------------------------------------
   // Frame tracking
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         en_d_r <= 1'b1;
         tog_d_r <= 1'b0;
      end else if (core_ce_in) begin
         en_d_r <= en_s;
         tog_d_r <= tog_s;
      end
   end

   assign en_rise = en_s & ~en_d_r;
   assign en_fall = en_d_r & ~en_s;
   assign tog_evt = tog_s ^ tog_d_r;

   // Word held until enable drops
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_word_r <= '0;
      end else if (core_ce_in && tog_evt) begin
         pend_word_r <= frame_r;
      end
   end

   // Capture wins over frame start
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_r <= 1'b0;
      end else if (core_ce_in) begin
         if (tog_evt) begin
            pend_r <= 1'b1;
         end else if (en_rise || en_fall) begin
            pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bad_r <= 1'b0;
      end else if (core_ce_in) begin
         if (over_s) begin
            bad_r <= 1'b1;
         end else if (en_rise || en_fall) begin
            bad_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Word decode
   // ------------------------------------------------------------
   // address then payload
   assign pend_addr = pend_word_r[FRAME_BITS-1 -: ADDR_W];
   assign pend_data = pend_word_r[DATA_W-1:0];
   assign commit = en_fall & pend_r & ~bad_r & ~over_s;
   assign f_ok = pend_data[F_LSB +: F_W] <= F_MAX;
   assign hit_uhf = commit && f_ok && pend_addr == ADDR_UHF;
   assign hit_sband = commit && f_ok && pend_addr == ADDR_SBAND;
   assign hit_edge = commit && pend_addr == ADDR_EDGE;

   // ------------------------------------------------------------
   // Programming registers
   // ------------------------------------------------------------
   // load settings
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         uhf_word_r <= UHF_RST;
         sband_word_r <= SBAND_RST;
         edge_word_r <= EDGE_RST;
      end else if (core_ce_in) begin
         if (hit_uhf) begin
            uhf_word_r <= pend_data;
         end
         if (hit_sband) begin
            sband_word_r <= pend_data;
         end
         if (hit_edge) begin
            edge_word_r <= pend_data;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         uhf_done_r <= 1'b0;
         sband_done_r <= 1'b0;
         edge_done_r <= 1'b0;
      end else if (core_ce_in) begin
         uhf_done_r <= uhf_done_r | hit_uhf;
         sband_done_r <= sband_done_r | hit_sband;
         edge_done_r <= edge_done_r | hit_edge;
      end
   end

   // Load and reject strobes
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         loaded_r <= 1'b0;
         rejected_r <= 1'b0;
      end else if (core_ce_in) begin
         loaded_r <= hit_uhf | hit_sband | hit_edge;
         rejected_r <= en_fall & ~(hit_uhf | hit_sband | hit_edge);
      end
   end

   // ------------------------------------------------------------
   // Synthesizer field decode
   // ------------------------------------------------------------
   // UHF loop ratio
   dssp_word u_uhf_word (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .ce_in(core_ce_in),
      .word_in(uhf_word_r),
      .n_out(uhf_n_out),
      .s_out(uhf_s_out),
      .f_out(uhf_f_out),
      .ratio_out(uhf_ratio_out)
   );

   dssp_word u_sband_word (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .ce_in(core_ce_in),
      .word_in(sband_word_r),
      .n_out(sband_n_out),
      .s_out(sband_s_out),
      .f_out(sband_f_out),
      .ratio_out(sband_ratio_out)
   );

   assign uhf_post_div_out = 8'(2 * UHF_M);

   // ------------------------------------------------------------
   // Oscillator select and gain
   // ------------------------------------------------------------
   // one oscillator only
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         first_r <= 1'b0;
         second_r <= 1'b0;
      end else if (core_ce_in) begin
         first_r <= sband_done_r & ~pin_s[0];
         second_r <= sband_done_r & pin_s[0];
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gain_r <= '0;
         tx_on_r <= 1'b0;
      end else if (core_ce_in) begin
         gain_r <= pin_s[6:2];
         tx_on_r <= pin_s[1];
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign edge_polarity_choice_out = edge_word_r[PS_BIT];
   assign ref_rising_edge_out = edge_word_r[PS_BIT];
   assign sband_osc_first_out = first_r;
   assign sband_osc_second_out = second_r;
   assign tx_gain_out = gain_r;
   assign transmit_on_out = tx_on_r;
   assign fully_programmed_out = uhf_done_r & sband_done_r & edge_done_r;
   assign word_loaded_out = loaded_r;
   assign word_rejected_out = rejected_r;
endmodule : dssp_top
`default_nettype wire

/* File: dv/dssp_checker.sv */
`default_nettype none
module dssp_checker
   import dssp_pkg::*;
#(
   parameter int UHF_M = UHF_M_DEF
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic core_ce_in,
   input wire logic ser_enable_in,
   input wire logic [GAIN_W-1:0] gain_in,
   input wire logic [N_W-1:0] uhf_n_out,
   input wire logic [S_W-1:0] uhf_s_out,
   input wire logic [F_W-1:0] uhf_f_out,
   input wire logic [RATIO_W-1:0] uhf_ratio_out,
   input wire logic [7:0] uhf_post_div_out,
   input wire logic [F_W-1:0] sband_f_out,
   input wire logic edge_polarity_choice_out,
   input wire logic ref_rising_edge_out,
   input wire logic sband_osc_first_out,
   input wire logic sband_osc_second_out,
   input wire logic [GAIN_W-1:0] tx_gain_out,
   input wire logic fully_programmed_out,
   input wire logic word_loaded_out,
   input wire logic word_rejected_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   property p_osc_one;
      !(sband_osc_first_out && sband_osc_second_out);
   endproperty
   a_osc_one: assert property (p_osc_one) else $error("both oscillators on");
   property p_edge_sel;
      $changed(ref_rising_edge_out) |-> word_loaded_out
         && ref_rising_edge_out == edge_polarity_choice_out;
   endproperty
   a_edge_sel: assert property (p_edge_sel) else $error("edge select mismatch");
   property p_f_range;
      uhf_f_out <= F_MAX && sband_f_out <= F_MAX;
   endproperty
   a_f_range: assert property (p_f_range) else $error("partial step above 17");
   property p_ratio;
      uhf_ratio_out != '0 |-> uhf_ratio_out == RATIO_W'(18 * (8 * (int'(uhf_n_out) + 3)
         - int'(uhf_s_out)) - int'(uhf_f_out));
   endproperty
   a_ratio: assert property (p_ratio) else $error("loop ratio wrong");
   property p_post_div;
      uhf_post_div_out == 8'(2 * UHF_M);
   endproperty
   a_post_div: assert property (p_post_div) else $error("post divider wrong");
   property p_strobe;
      (word_loaded_out || word_rejected_out) |-> !$past(ser_enable_in, 3)
         && $past(ser_enable_in, 6) && !(word_loaded_out && word_rejected_out);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe not after enable drop");
   property p_pulse;
      word_loaded_out |=> !word_loaded_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("load strobe too long");
   property p_gain;
      core_ce_in [*4] |-> tx_gain_out == $past(gain_in, 3);
   endproperty
   a_gain: assert property (p_gain) else $error("gain word latency");
   property p_prog_hold;
      fully_programmed_out |=> fully_programmed_out;
   endproperty
   a_prog_hold: assert property (p_prog_hold) else $error("programmed flag dropped");
   property p_edge_load;
      $changed(edge_polarity_choice_out) |-> word_loaded_out || $past(word_loaded_out);
   endproperty
   a_edge_load: assert property (p_edge_load) else $error("edge bit moved unloaded");
endmodule : dssp_checker

bind dssp_top dssp_checker #(.UHF_M(UHF_M)) dssp_checker_i (.ref_clk_in, .sys_rst_in,
   .core_ce_in, .ser_enable_in, .gain_in, .uhf_n_out, .uhf_s_out, .uhf_f_out,
   .uhf_ratio_out, .uhf_post_div_out, .sband_f_out, .edge_polarity_choice_out,
   .ref_rising_edge_out, .sband_osc_first_out, .sband_osc_second_out, .tx_gain_out,
   .fully_programmed_out, .word_loaded_out, .word_rejected_out);
`default_nettype wire

/* File: dv/dssp_host_model.sv */
`default_nettype none
module dssp_host_model (
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic ser_enable_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ser_clk_out = 1'b1;
      ser_data_out = 1'b1;
      // Enable rests high until the host first drives it
      ser_enable_out = 1'b1;
   end
   task automatic send_frame(input logic [31:0] bits, input int n);
      ser_enable_out = 1'b1;
      #3.7;
      for (int i = n - 1; i >= 0; i--) begin
         ser_clk_out = 1'b0;
         ser_data_out = bits[i];
         #3;
         ser_clk_out = 1'b1;
         #3;
      end
      // Data no longer valid
      ser_data_out = ~ser_data_out;
      #30;
      ser_enable_out = 1'b0;
      #60;
   endtask : send_frame
endmodule : dssp_host_model
`default_nettype wire

/* File: dv/tb_dssp_top.sv */
`default_nettype none
module tb_dssp_top
   import dssp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic core_ce_in = 1'b1;
   logic ser_clk, ser_data, ser_en;
   logic [GAIN_W-1:0] gain_in = '0;
   logic transmit_on_in = 1'b0;
   logic osc_pick = 1'b0;
   logic [N_W-1:0] un, sn;
   logic [S_W-1:0] us, ss;
   logic [F_W-1:0] uf, sf;
   logic [RATIO_W-1:0] ur, sr;
   logic [7:0] post_div;
   logic edge_sel, rising, osc_a, osc_b, tx_on, prog, loaded, rejected;
   logic [GAIN_W-1:0] tx_gain;
   logic [31:0] seed = 32'h00000061;
   int n_mismatch = 0;
   int total_checks = 0;
   int n_load = 0;
   int n_rej = 0;
   always #4 ref_clk_in = ~ref_clk_in;
   dssp_host_model dssp_host_model_i (.ser_clk_out(ser_clk), .ser_data_out(ser_data),
      .ser_enable_out(ser_en));
   dssp_top dssp_top_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .core_ce_in(core_ce_in), .ser_clk_in(ser_clk), .ser_data_in(ser_data),
      .ser_enable_in(ser_en), .gain_in(gain_in), .transmit_on_in(transmit_on_in),
      .sband_osc_pick_in(osc_pick), .uhf_n_out(un), .uhf_s_out(us), .uhf_f_out(uf),
      .uhf_ratio_out(ur), .uhf_post_div_out(post_div), .sband_n_out(sn), .sband_s_out(ss),
      .sband_f_out(sf), .sband_ratio_out(sr), .edge_polarity_choice_out(edge_sel),
      .ref_rising_edge_out(rising), .sband_osc_first_out(osc_a),
      .sband_osc_second_out(osc_b), .tx_gain_out(tx_gain), .transmit_on_out(tx_on),
      .fully_programmed_out(prog), .word_loaded_out(loaded), .word_rejected_out(rejected));
   always @(posedge ref_clk_in) begin
      if (loaded === 1'b1) n_load++;
      if (rejected === 1'b1) n_rej++;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [16:0] exp_ratio(input int n, input int s, input int f);
      return 17'(18 * (8 * (n + 3) - s) - f);
   endfunction : exp_ratio
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk
   task automatic frame(input logic [7:0] a, input logic [15:0] d, input int n, input bit ok);
      int l0, r0;
      l0 = n_load;
      r0 = n_rej;
      @(posedge ref_clk_in);
      #1;
      dssp_host_model_i.send_frame({8'h00, a, d}, n);
      for (int k = 0; k < 20 && n_load + n_rej == l0 + r0; k++) @(posedge ref_clk_in);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk("loaded", 32'(ok), 32'(n_load - l0));
      chk("rejected", 32'(!ok), 32'(n_rej - r0));
   endtask : frame
   task automatic chk_synth(input bit sb, input logic [15:0] d);
      chk("n_field", d[15:8], sb ? sn : un);
      chk("s_field", d[7:5], sb ? ss : us);
      chk("f_field", d[4:0], sb ? sf : uf);
      chk("ratio", exp_ratio(d[15:8], d[7:5], d[4:0]), sb ? sr : ur);
   endtask : chk_synth
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   initial begin
      #30000;
      n_mismatch++;
      conclude();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      logic [15:0] d;
      logic [31:0] r;
      logic [7:0] resv [3];
      resv = '{8'h00, 8'h04, 8'hFF};
      repeat (5) @(posedge ref_clk_in);
      #1;
      sys_rst_in = 1'b0;
      repeat (5) @(posedge ref_clk_in);
      #1;
      chk("ratio_rst", exp_ratio(0, 0, 0), ur);
      chk("post_div", 2 * UHF_M_DEF, post_div);
      chk("prog_rst", 0, prog);
      chk("osc_rst", 0, {osc_a, osc_b});
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         r = xs();
         d = {r[7:0], r[10:8], 5'(r[20:16] % 18)};
         frame(ADDR_UHF, d, 24, 1'b1);
         chk_synth(1'b0, d);
      end
      $display("test uhf done");
      frame(ADDR_SBAND, 16'hFFF1, 24, 1'b1);
      chk_synth(1'b1, 16'hFFF1);
      frame(ADDR_SBAND, 16'h1232, 24, 1'b0);
      chk_synth(1'b1, 16'hFFF1);
      $display("test sband done");
      frame(ADDR_EDGE, 16'h0100, 24, 1'b1);
      chk("edge_rise", 2'b11, {edge_sel, rising});
      chk("programmed", 1, prog);
      frame(ADDR_EDGE, 16'h0000, 24, 1'b1);
      chk("edge_fall", 2'b00, {edge_sel, rising});
      foreach (resv[i]) begin
         frame(resv[i], 16'h0100, 24, 1'b0);
         chk("reserved", 0, edge_sel);
      end
      frame(ADDR_EDGE, 16'h0100, 23, 1'b0);
      frame(ADDR_EDGE, 16'h0100, 25, 1'b0);
      chk("bad_len", 0, edge_sel);
      chk_synth(1'b0, d);
      $display("test edge done");
      for (int p = 0; p < 2; p++) begin
         osc_pick = 1'(p);
         repeat (6) @(posedge ref_clk_in);
         #1;
         chk("osc_sel", p ? 2'b01 : 2'b10, {osc_a, osc_b});
      end
      for (int i = 0; i < 8; i++) begin
         r = (i == 0) ? 32'h0000003F : xs();
         @(posedge ref_clk_in);
         #1;
         gain_in = r[4:0];
         transmit_on_in = r[5];
         repeat (4) @(posedge ref_clk_in);
         #1;
         chk("gain", r[5:0], {tx_on, tx_gain});
      end
      // Clock enable low freezes the gain path
      @(posedge ref_clk_in);
      #1;
      core_ce_in = 1'b0;
      gain_in = ~r[4:0];
      repeat (4) @(posedge ref_clk_in);
      #1;
      chk("ce_hold", r[4:0], tx_gain);
      core_ce_in = 1'b1;
      repeat (4) @(posedge ref_clk_in);
      #1;
      chk("ce_run", 5'(~r[4:0]), tx_gain);
      $display("test gain done");
      conclude();
   end
endmodule : tb_dssp_top
`default_nettype wire
